// >>> tb/ccirq_asserts.sv
// Port checks for the comparator control block.
`timescale 1ns/100ps
module ccirq_asserts
   import ccirq_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic clkEn,
   input wire ccirq_bus_t busReq,
   input wire logic [7:0] rdData,
   input wire ccirq_cmp_t cmpAnalog,
   input wire logic sleepEnter,
   input wire ccirq_cmp_t cmpEnableOut,
   input wire logic irqRequest,
   input wire logic wakeRequest,
   input wire logic asleep
);
   logic [1:0] intEn;
   wire ctlRd = clkEn && busReq.rd && busReq.addr == 2'h0;
   always_ff @(posedge clock) begin
      if (srst) begin
         intEn <= 2'h0;
      end else if (clkEn && busReq.wr && busReq.addr == 2'h3) begin
         intEn <= busReq.wdata[7:6];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence wakeUp;
      wakeRequest && !asleep ##1 !wakeRequest;
   endsequence
   reset_state_a:
      assert property (disable iff (1'b0) srst |=> cmpEnableOut == 3'h0 && !irqRequest && !asleep)
      else $error("state not cleared by reset");
   idle_read_a:
      assert property (clkEn && !busReq.rd |=> rdData == 8'h00) else $error("read data not zero");
   en_write_a:
      assert property (clkEn && busReq.wr && busReq.addr == 2'h0 |=> cmpEnableOut == $past(busReq.wdata[2:0]))
      else $error("enable write lost");
   gap_zero_a:
      assert property (ctlRd |=> rdData[4:3] == 2'h0) else $error("gap bits not zero");
   en_readback_a:
      assert property (ctlRd |=> rdData[2:0] == cmpEnableOut) else $error("enable readback");
   result_mask_a:
      assert property (ctlRd |=> (rdData[7:5] & ~cmpEnableOut) == 3'h0) else $error("disabled result");
   flag_bits_a:
      assert property (clkEn && busReq.rd && busReq.addr == 2'h1 |=> rdData[7:4] == 4'h0 && !rdData[0])
      else $error("flag spare bits");
   irq_gate_a:
      assert property ($past(intEn) != 2'h3 |-> !irqRequest) else $error("request not gated");
   sleep_enter_a:
      assert property (clkEn && sleepEnter && !asleep |=> asleep) else $error("sleep not entered");
   wake_pulse_a:
      assert property ($rose(wakeRequest) |-> $fell(asleep) ##0 wakeUp) else $error("wake pulse");
endmodule : ccirq_asserts
bind ccirq_core ccirq_asserts portCheck (.clock(clock), .srst(srst), .clkEn(clkEn), .busReq(busReq),
   .rdData(rdData), .cmpAnalog(cmpAnalog), .sleepEnter(sleepEnter), .cmpEnableOut(cmpEnableOut),
   .irqRequest(irqRequest), .wakeRequest(wakeRequest), .asleep(asleep));

// >>> tb/ccirq_cmp_model.sv
// Comparator model that sets each result from input level against reference.
`timescale 1ns/100ps
module ccirq_cmp_model
   import ccirq_pkg::*;
(
   input wire logic [23:0] posLevels,
   input wire logic [7:0] refLevel,
   output ccirq_cmp_t cmpAnalog
);
   always_comb begin
      for (int n = 0; n < 3; n++) begin
         cmpAnalog[n] = posLevels[8*n+:8] > refLevel;
      end
   end
endmodule : ccirq_cmp_model

// >>> tb/testbench.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/100ps
module testbench
   import ccirq_pkg::*;
;
   logic clock = 0;
   logic srst = 1;
   logic clkEn = 1;
   logic sleepEnter = 0;
   ccirq_bus_t busReq = '0;
   logic [7:0] rdData;
   logic [23:0] posLevels;
   ccirq_cmp_t cmpAnalog;
   ccirq_cmp_t cmpEnableOut;
   logic irqRequest;
   logic wakeRequest;
   logic asleep;
   int mismatches = 0;
   int n_compared = 0;
   int seed = 98;
   int i;
   always #12.5 clock = ~clock;
   ccirq_cmp_model cmp (.posLevels(posLevels), .refLevel(8'h80), .cmpAnalog(cmpAnalog));
   ccirq_core dut (.clock(clock), .srst(srst), .clkEn(clkEn), .busReq(busReq), .rdData(rdData),
      .cmpAnalog(cmpAnalog), .sleepEnter(sleepEnter), .cmpEnableOut(cmpEnableOut),
      .irqRequest(irqRequest), .wakeRequest(wakeRequest), .asleep(asleep));
   function automatic logic [7:0] expCtrl(input logic [2:0] en);
      logic [2:0] c;
      for (int n = 0; n < 3; n++) begin
         c[n] = posLevels[8*n+:8] > 8'h80;
      end
      return {c & en, 2'h0, en};
   endfunction : expCtrl
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      busReq <= '0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clock);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      busReq <= '0;
      #1;
      chk("rdData", e, rdData);
   endtask : rd
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
   initial begin
      // Odd levels never equal the reference, so every result is defined.
      posLevels = 24'($random(seed)) | 24'h010101;
      repeat (12) @(posedge clock);
      srst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         rd(i[1:0], 8'h00);
      end
      wr(2'h0, 8'hff);
      rd(2'h0, expCtrl(3'h7));
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h00);
      posLevels <= posLevels ^ 24'h808080;
      repeat (6) @(posedge clock);
      rd(2'h1, 8'h0e);
      chk("irq", 8'h00, {7'h0, irqRequest});
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h0e);
      rd(2'h0, expCtrl(3'h7));
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h00);
      wr(2'h1, 8'h0e);
      rd(2'h1, 8'h0e);
      wr(2'h2, 8'h0e);
      for (i = 0; i < 4; i++) begin
         wr(2'h3, 8'(i << 6));
         @(posedge clock);
         #1;
         chk("irq", {7'h0, i == 3}, {7'h0, irqRequest});
      end
      wr(2'h3, 8'h00);
      wr(2'h1, 8'h00);
      @(posedge clock);
      sleepEnter <= 1'b1;
      @(posedge clock);
      sleepEnter <= 1'b0;
      #1;
      chk("asleep", 8'h01, {7'h0, asleep});
      posLevels <= posLevels ^ 24'h808080;
      i = 0;
      while (wakeRequest !== 1'b1 && i < 10) begin
         @(posedge clock);
         #1;
         i++;
      end
      chk("wake", 8'h01, {7'h0, wakeRequest});
      chk("asleep", 8'h00, {7'h0, asleep});
      rd(2'h0, expCtrl(3'h7));
      // A write presented while the clock enable is low must not land.
      @(posedge clock);
      clkEn <= 1'b0;
      busReq <= '{addr: 2'h0, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
      repeat (3) @(posedge clock);
      busReq <= '0;
      clkEn <= 1'b1;
      rd(2'h0, expCtrl(3'h7));
      summarize();
   end
endmodule : testbench

// >>> verilog/ccirq_consts.svh
// Constants for the comparator control and interrupt block.
`ifndef CCIRQ_CONSTS_SVH
`define CCIRQ_CONSTS_SVH

`define CCIRQ_NUM_CMP 3
`define CCIRQ_ADDR_W 2
`define CCIRQ_DATA_W 8

`define CCIRQ_OFF_CTRL 2'h0
`define CCIRQ_OFF_FLAGS 2'h1
`define CCIRQ_OFF_IRQEN 2'h2
`define CCIRQ_OFF_INTCTL 2'h3

`define CCIRQ_EN_LSB 0
`define CCIRQ_EN_MSB 2
`define CCIRQ_RES_LSB 5
`define CCIRQ_RES_MSB 7
`define CCIRQ_GAP_LSB 3
`define CCIRQ_GAP_MSB 4
`define CCIRQ_FLG_LSB 1
`define CCIRQ_FLG_MSB 3
`define CCIRQ_PERIPH_EN_BIT 6
`define CCIRQ_GLOBAL_EN_BIT 7

`define CCIRQ_CMP_ZERO 3'h0
`define CCIRQ_GAP_ZERO 2'h0
`define CCIRQ_DATA_ZERO 8'h00
`define CCIRQ_BIT0_ZERO 1'h0
`define CCIRQ_HI_ZERO 4'h0
`define CCIRQ_LO_ZERO 6'h00

`endif

// >>> verilog/ccirq_core.sv
// Comparator control, result snapshot and interrupt flag logic.
//
// Summary of operation
// - Three comparator channels, each with enable, result bit and interrupt flag.
// - Results reach no pin; software reads them only in the control register.
// - Control bits 2..0 enable comparators 2..0; one means enabled.
// - Result bit reads one when positive input is above the reference.
// - Result bits sit at control bits 7..5, read-only; writes ignored.
// - Control bits 4 and 3 always read as zero.
// - A change of a comparator result sets its flag, flag bits 3..1.
// - Software clears a flag by writing zero; writing one sets it.
// - Request reaches core only with channel, peripheral and global enables set.
// - Flags still set on a change while any enable is clear.
// - Any control register read or write refreshes the result snapshot.
// - Mismatch keeps setting the flag; software reads control before clearing.
// - A change coinciding with a control access may leave the flag clear.
// - Comparators keep working in sleep; a set flag with its channel enable set wakes the device, whatever the peripheral and global enables.
// - Waking from sleep leaves the control register unchanged.
// - Reset clears the control register, turning every comparator off.
// - Results may be invalid for a settling delay after configuration change.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps

`include "ccirq_consts.svh"

module ccirq_core
   import ccirq_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic clkEn,
   input wire ccirq_bus_t busReq,
   output logic [`CCIRQ_DATA_W-1:0] rdData,
   input wire ccirq_cmp_t cmpAnalog,
   input wire logic sleepEnter,
   output ccirq_cmp_t cmpEnableOut,
   output logic irqRequest,
   output logic wakeRequest,
   output logic asleep
);

   function automatic logic regHit(
      input logic [`CCIRQ_ADDR_W-1:0] addr,
      input logic [`CCIRQ_ADDR_W-1:0] offset
   );
      regHit = (addr == offset);
   endfunction : regHit

   // Register state.
   ccirq_cmp_t cmpEnableField;
   ccirq_cmp_t cmpIrqEnable;
   ccirq_cmp_t cmpIrqFlag;
   logic peripheralIrqEnable;
   logic globalIrqEnable;

   // Change detection state.
   ccirq_cmp_t syncStage1;
   ccirq_cmp_t syncStage2;
   ccirq_cmp_t snapshot;

   ccirq_pwr_t pwrState;
   ccirq_pwr_t next_pwrState;

   // Bus decode.
   wire logic hitCtrl;
   wire logic hitFlags;
   wire logic hitIrqEn;
   wire logic hitIntCtl;
   wire logic wrCtrl;
   wire logic wrFlags;
   wire logic wrIrqEn;
   wire logic wrIntCtl;
   wire logic accessCtrl;

   assign hitCtrl = regHit(busReq.addr, `CCIRQ_OFF_CTRL);
   assign hitFlags = regHit(busReq.addr, `CCIRQ_OFF_FLAGS);
   assign hitIrqEn = regHit(busReq.addr, `CCIRQ_OFF_IRQEN);
   assign hitIntCtl = regHit(busReq.addr, `CCIRQ_OFF_INTCTL);
   assign wrCtrl = busReq.wr & hitCtrl;
   assign wrFlags = busReq.wr & hitFlags;
   assign wrIrqEn = busReq.wr & hitIrqEn;
   assign wrIntCtl = busReq.wr & hitIntCtl;
   assign accessCtrl = (busReq.wr | busReq.rd) & hitCtrl;

   // Live results; a disabled comparator reports zero.
   wire ccirq_cmp_t cmpResultBits;
   assign cmpResultBits = syncStage2 & cmpEnableField;

   // Per-channel change detection.
   wire ccirq_cmp_t mismatch;
   wire ccirq_cmp_t flagSet;
   wire ccirq_cmp_t writtenFlags;
   wire ccirq_cmp_t next_cmpIrqFlag;
   wire ccirq_cmp_t next_snapshot;

   genvar ch;
   generate
      for (ch = 0; ch < `CCIRQ_NUM_CMP; ch = ch + 1) begin : g_chan
         assign mismatch[ch] = cmpResultBits[ch] ^ snapshot[ch];
         assign flagSet[ch] = mismatch[ch] & ~accessCtrl;
         assign writtenFlags[ch] = wrFlags ? busReq.wdata[`CCIRQ_FLG_LSB + ch] : cmpIrqFlag[ch];
         assign next_cmpIrqFlag[ch] = writtenFlags[ch] | flagSet[ch];
         assign next_snapshot[ch] = accessCtrl ? cmpResultBits[ch] : snapshot[ch];
      end
   endgenerate

   // Register write values.
   wire ccirq_cmp_t next_cmpEnableField;
   wire ccirq_cmp_t next_cmpIrqEnable;
   wire logic next_peripheralIrqEnable;
   wire logic next_globalIrqEnable;

   assign next_cmpEnableField = wrCtrl ? busReq.wdata[`CCIRQ_EN_MSB:`CCIRQ_EN_LSB] : cmpEnableField;
   assign next_cmpIrqEnable = wrIrqEn ? busReq.wdata[`CCIRQ_FLG_MSB:`CCIRQ_FLG_LSB] : cmpIrqEnable;
   assign next_peripheralIrqEnable = wrIntCtl ? busReq.wdata[`CCIRQ_PERIPH_EN_BIT] : peripheralIrqEnable;
   assign next_globalIrqEnable = wrIntCtl ? busReq.wdata[`CCIRQ_GLOBAL_EN_BIT] : globalIrqEnable;

   // Interrupt gating; flags are set regardless of these enables.
   wire ccirq_cmp_t pending;
   wire logic anyPending;
   wire logic next_irqRequest;

   assign pending = cmpIrqFlag & cmpIrqEnable;
   assign anyPending = |pending;
   assign next_irqRequest = anyPending & peripheralIrqEnable & globalIrqEnable;

   // Read data images.
   wire logic [`CCIRQ_DATA_W-1:0] ctrlImage;
   wire logic [`CCIRQ_DATA_W-1:0] flagsImage;
   wire logic [`CCIRQ_DATA_W-1:0] irqEnImage;
   wire logic [`CCIRQ_DATA_W-1:0] intCtlImage;
   wire logic [`CCIRQ_DATA_W-1:0] next_rdData;

   assign ctrlImage = {cmpResultBits, `CCIRQ_GAP_ZERO, cmpEnableField};
   assign flagsImage = {`CCIRQ_HI_ZERO, cmpIrqFlag, `CCIRQ_BIT0_ZERO};
   assign irqEnImage = {`CCIRQ_HI_ZERO, cmpIrqEnable, `CCIRQ_BIT0_ZERO};
   assign intCtlImage = {globalIrqEnable, peripheralIrqEnable, `CCIRQ_LO_ZERO};

   assign next_rdData = !busReq.rd ? `CCIRQ_DATA_ZERO :
                        hitCtrl ? ctrlImage :
                        hitFlags ? flagsImage :
                        hitIrqEn ? irqEnImage :
                        intCtlImage;

   // Sleep tracking; the core clock keeps running so flags stay live in sleep.
   wire logic wakeNow;

   assign wakeNow = (pwrState == CCIRQ_ASLEEP) & anyPending;

   always_comb begin
      next_pwrState = pwrState;
      unique case (pwrState)
         CCIRQ_AWAKE: begin
            if (sleepEnter) begin
               next_pwrState = CCIRQ_ASLEEP;
            end
         end
         CCIRQ_ASLEEP: begin
            if (anyPending) begin
               next_pwrState = CCIRQ_AWAKE;
            end
         end
         default: begin
            next_pwrState = CCIRQ_AWAKE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         syncStage1 <= `CCIRQ_CMP_ZERO;
         syncStage2 <= `CCIRQ_CMP_ZERO;
      end else if (clkEn) begin
         syncStage1 <= cmpAnalog;
         syncStage2 <= syncStage1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cmpEnableField <= `CCIRQ_CMP_ZERO;
         cmpIrqEnable <= `CCIRQ_CMP_ZERO;
         peripheralIrqEnable <= 1'b0;
         globalIrqEnable <= 1'b0;
      end else if (clkEn) begin
         cmpEnableField <= next_cmpEnableField;
         cmpIrqEnable <= next_cmpIrqEnable;
         peripheralIrqEnable <= next_peripheralIrqEnable;
         globalIrqEnable <= next_globalIrqEnable;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cmpIrqFlag <= `CCIRQ_CMP_ZERO;
         snapshot <= `CCIRQ_CMP_ZERO;
      end else if (clkEn) begin
         cmpIrqFlag <= next_cmpIrqFlag;
         snapshot <= next_snapshot;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pwrState <= CCIRQ_AWAKE;
         wakeRequest <= 1'b0;
         asleep <= 1'b0;
      end else if (clkEn) begin
         pwrState <= next_pwrState;
         wakeRequest <= wakeNow;
         asleep <= (next_pwrState == CCIRQ_ASLEEP);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdData <= `CCIRQ_DATA_ZERO;
         irqRequest <= 1'b0;
         cmpEnableOut <= `CCIRQ_CMP_ZERO;
      end else if (clkEn) begin
         rdData <= next_rdData;
         irqRequest <= next_irqRequest;
         cmpEnableOut <= next_cmpEnableField;
      end
   end

endmodule : ccirq_core

// >>> verilog/ccirq_pkg.sv
// Types shared by the comparator control and interrupt block.
`include "ccirq_consts.svh"

package ccirq_pkg;

   typedef logic [`CCIRQ_NUM_CMP-1:0] ccirq_cmp_t;

   typedef struct packed {
      logic [`CCIRQ_ADDR_W-1:0] addr;
      logic [`CCIRQ_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } ccirq_bus_t;

   typedef enum logic [1:0] {
      CCIRQ_AWAKE = 2'b01,
      CCIRQ_ASLEEP = 2'b10
   } ccirq_pwr_t;

endpackage : ccirq_pkg
